//--- hdlc_dist_pkg.sv
package hdlc_dist_pkg;

    // Engine population and stream geometry.
    localparam int NUM_ENG = 32;
    localparam int DMA_CHAN_MAX = 64;
    localparam int NUM_MEZZ = 4;
    localparam int ENG_PER_MEZZ = 8;
    localparam int SLOTS_PER_FRAME = 64;
    localparam int BITS_PER_SLOT = 8;
    localparam int CHAN_W = 5;
    localparam int SLOT_W = 6;

    // Bit timing: the stream rate is derived exactly from the clock period.
    localparam int CLK_PERIOD_PS = 8000;
    localparam int STREAM_RATE_KBPS = 4096;
    localparam logic [16:0] CLK_RATE_KHZ = 17'(1_000_000_000 / CLK_PERIOD_PS);
    localparam logic [16:0] NCO_STEP = 17'(STREAM_RATE_KBPS);
    localparam logic [8:0] FRAME_FIRST_BIT = 9'h000;

    // Reset values of the slot switch and idle line level.
    localparam logic [SLOT_W-1:0] CMD_SLOT_RST = 6'h00;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;

    // Framing constants of the command pipes.
    localparam logic [7:0] HDLC_FLAG = 8'h7E;
    localparam logic [7:0] HDLC_ABORT = 8'h7F;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [15:0] CRC_RESIDUE = 16'hF0B8;
    localparam logic [2:0] STUFF_RUN = 3'h5;
    localparam logic [2:0] FLAG_RUN = 3'h6;
    localparam logic [4:0] BYTE_BITS = 5'h08;
    localparam logic [4:0] FCS_BITS = 5'h10;

    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_DATA = 4'h2,
        TX_FCS = 4'h4,
        TX_CLOSE = 4'h8
    } tx_state_t;

    // Reflected CRC-16 step for one bit, least significant bit first.
    function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
        crc_bit = {1'b0, c[15:1]} ^ (((c[0] ^ b) == 1'b1) ? CRC_POLY : 16'h0000);
    endfunction

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = crc_bit(r, d[i]);
        end
        crc_byte = r;
    endfunction

endpackage

//--- pipe_if.sv
interface pipe_if;
    logic bit_en;
    logic rx_bit;
    logic tx_load;
    logic [7:0] tx_byte;
    logic tx_last;
    logic tx_bit;
    logic tx_ready;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic rx_end;
    logic rx_ok;

    modport pipe (
        input bit_en, rx_bit, tx_load, tx_byte, tx_last,
        output tx_bit, tx_ready, rx_valid, rx_byte, rx_end, rx_ok
    );

    modport ctl (
        output bit_en, rx_bit, tx_load, tx_byte, tx_last,
        input tx_bit, tx_ready, rx_valid, rx_byte, rx_end, rx_ok
    );
endinterface

//--- hdlc_pipe.sv
module hdlc_pipe (
    // Clock and reset.
    input logic ref_clk,
    input logic srst,
    // Slot-paced link to the distributor.
    pipe_if.pipe bus
);
    import hdlc_dist_pkg::*;

    tx_state_t state_ff, nxt_state;
    logic [15:0] sh_ff, nxt_sh;
    logic [4:0] cnt_ff, nxt_cnt;
    logic [2:0] ones_ff, nxt_ones;
    logic [15:0] crc_ff, nxt_crc;
    logic last_ff, nxt_last;
    logic take_buf;
    logic [7:0] buf_ff;
    logic buf_full_ff;
    logic buf_last_ff;

    wire stuff_now = (ones_ff == STUFF_RUN);
    wire in_stuff_zone = (state_ff == TX_DATA) || (state_ff == TX_FCS);

    assign bus.tx_bit = stuff_now ? 1'b0 : sh_ff[0];
    assign bus.tx_ready = ~buf_full_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_sh = sh_ff;
        nxt_cnt = cnt_ff;
        nxt_ones = ones_ff;
        nxt_crc = crc_ff;
        nxt_last = last_ff;
        take_buf = 1'b0;
        if (bus.bit_en && stuff_now) begin
            nxt_ones = 3'h0;
        end else if (bus.bit_en) begin
            nxt_sh = {1'b0, sh_ff[15:1]};
            nxt_cnt = 5'(cnt_ff - 5'h01);
            nxt_ones = (in_stuff_zone && sh_ff[0]) ? 3'(ones_ff + 3'h1) : 3'h0;
            if (state_ff == TX_DATA) begin
                nxt_crc = crc_bit(crc_ff, sh_ff[0]);
            end
            if (cnt_ff == 5'h01) begin
                nxt_sh = {8'h00, HDLC_FLAG};
                nxt_cnt = BYTE_BITS;
                unique case (state_ff)
                    TX_IDLE: begin
                        if (buf_full_ff) begin
                            nxt_sh = {8'h00, buf_ff};
                            nxt_crc = CRC_INIT;
                            nxt_last = buf_last_ff;
                            nxt_state = TX_DATA;
                            take_buf = 1'b1;
                        end
                    end
                    TX_DATA: begin
                        if (last_ff) begin
                            nxt_sh = ~nxt_crc;
                            nxt_cnt = FCS_BITS;
                            nxt_state = TX_FCS;
                        end else if (buf_full_ff) begin
                            nxt_sh = {8'h00, buf_ff};
                            nxt_last = buf_last_ff;
                            take_buf = 1'b1;
                        end else begin
                            nxt_sh = {8'h00, HDLC_ABORT};
                            nxt_state = TX_CLOSE;
                        end
                    end
                    TX_FCS: begin
                        nxt_state = TX_CLOSE;
                    end
                    TX_CLOSE: begin
                        nxt_state = TX_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_ff <= TX_IDLE;
            sh_ff <= {8'h00, HDLC_FLAG};
            cnt_ff <= BYTE_BITS;
            ones_ff <= 3'h0;
            crc_ff <= CRC_INIT;
            last_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            sh_ff <= nxt_sh;
            cnt_ff <= nxt_cnt;
            ones_ff <= nxt_ones;
            crc_ff <= nxt_crc;
            last_ff <= nxt_last;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            buf_ff <= 8'h00;
            buf_full_ff <= 1'b0;
            buf_last_ff <= 1'b0;
        end else if (bus.tx_load) begin
            buf_ff <= bus.tx_byte;
            buf_full_ff <= 1'b1;
            buf_last_ff <= bus.tx_last;
        end else if (take_buf) begin
            buf_full_ff <= 1'b0;
        end
    end

    logic [2:0] rones_ff;
    logic [7:0] dat_ff;
    logic [2:0] dcnt_ff;
    logic inf_ff;
    logic [15:0] rcrc_ff;
    logic [7:0] p0_ff;
    logic [7:0] p1_ff;
    logic [1:0] pc_ff;
    logic rxv_ff;
    logic [7:0] rxb_ff;
    logic rend_ff;
    logic rok_ff;

    wire b = bus.rx_bit;
    wire [2:0] rones_nx = !b ? 3'h0 : (rones_ff == 3'h7) ? 3'h7 : 3'(rones_ff + 3'h1);
    wire is_flag = bus.bit_en && !b && (rones_ff == FLAG_RUN);
    wire is_abort = bus.bit_en && b && (rones_ff == FLAG_RUN);
    wire is_del = bus.bit_en && !b && (rones_ff == STUFF_RUN);
    wire take = bus.bit_en && inf_ff && !is_flag && !is_abort && !is_del;
    wire [7:0] full_byte = {b, dat_ff[7:1]};
    // The flag's own seven leading bits leave the byte counter at seven.
    wire crc_ok = is_flag && (pc_ff == 2'h2) && (dcnt_ff == 3'h7) && (rcrc_ff == CRC_RESIDUE);

    assign bus.rx_valid = rxv_ff;
    assign bus.rx_byte = rxb_ff;
    assign bus.rx_end = rend_ff;
    assign bus.rx_ok = rok_ff;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rones_ff <= 3'h0;
            dat_ff <= 8'h00;
            dcnt_ff <= 3'h0;
            inf_ff <= 1'b0;
            rcrc_ff <= CRC_INIT;
            p0_ff <= 8'h00;
            p1_ff <= 8'h00;
            pc_ff <= 2'h0;
            rxv_ff <= 1'b0;
            rxb_ff <= 8'h00;
            rend_ff <= 1'b0;
            rok_ff <= 1'b0;
        end else begin
            rxv_ff <= 1'b0;
            rend_ff <= 1'b0;
            if (bus.bit_en) begin
                rones_ff <= rones_nx;
            end
            if (is_flag || is_abort) begin
                inf_ff <= is_flag;
                dcnt_ff <= 3'h0;
                rcrc_ff <= CRC_INIT;
                pc_ff <= 2'h0;
                rend_ff <= inf_ff && (pc_ff != 2'h0);
                rok_ff <= crc_ok;
            end else if (take) begin
                dat_ff <= full_byte;
                dcnt_ff <= 3'(dcnt_ff + 3'h1);
                if (dcnt_ff == 3'h7) begin
                    rcrc_ff <= crc_byte(rcrc_ff, full_byte);
                    p0_ff <= p1_ff;
                    p1_ff <= full_byte;
                    if (pc_ff == 2'h2) begin
                        rxv_ff <= 1'b1;
                        rxb_ff <= p0_ff;
                    end else begin
                        pc_ff <= 2'(pc_ff + 2'h1);
                    end
                end
            end
        end
    end
endmodule

//--- hdlc_command_slot_distributor.sv
// Function
// - Thirty-two of the sixty-four possible pipe channels are built, one per engine.
// - Each pipe channel frames and unframes its traffic with no per-byte help.
// - Pipe channel bits form a multiplexed slot stream, channel n in slot n.
// - A programmable switch moves command slots onto engine streams and back.
// - Thirty-two engine streams run at 4.096 Mbps each.
// - Streams are grouped eight to each of four mezzanine locations.
// - Each engine stream is full duplex with 64 slots per frame.
// - One slot per engine stream carries commands; others carry voice.
// - Voice samples and command bits share each engine stream.
// - A command byte goes to any one engine or any chosen group.
// - Every engine has its own stream, slot and pipe channel.
module hdlc_command_slot_distributor (
    // Clock and reset.
    input logic ref_clk,
    input logic srst,
    // Command bytes from the processor side.
    input logic cmd_valid,
    input logic [hdlc_dist_pkg::NUM_ENG-1:0] cmd_group,
    input logic [7:0] cmd_byte,
    input logic cmd_last,
    output logic cmd_ready,
    // Response bytes toward the processor side.
    output logic rsp_valid,
    output logic [hdlc_dist_pkg::CHAN_W-1:0] rsp_chan,
    output logic [7:0] rsp_byte,
    output logic rsp_end,
    output logic rsp_ok,
    // Slot switch programming.
    input logic map_wr,
    input logic [hdlc_dist_pkg::CHAN_W-1:0] map_engine,
    input logic [hdlc_dist_pkg::CHAN_W-1:0] map_chan,
    input logic [hdlc_dist_pkg::SLOT_W-1:0] map_slot,
    // Voice traffic, one serial line per engine.
    input logic [hdlc_dist_pkg::NUM_ENG-1:0] pcm_in,
    output logic [hdlc_dist_pkg::NUM_ENG-1:0] pcm_out,
    // Engine streams per mezzanine location.
    output logic [hdlc_dist_pkg::NUM_MEZZ-1:0][hdlc_dist_pkg::ENG_PER_MEZZ-1:0] mezz_tx,
    input logic [hdlc_dist_pkg::NUM_MEZZ-1:0][hdlc_dist_pkg::ENG_PER_MEZZ-1:0] mezz_rx,
    // Stream timing toward the engines.
    output logic bit_stb,
    output logic frame_sync
);
    import hdlc_dist_pkg::*;

    function automatic logic slot_match(input logic [SLOT_W-1:0] slot, input logic [8:0] pos);
        slot_match = (pos[8:3] == slot);
    endfunction

    logic [16:0] nco_ff;
    logic stb_ff;
    logic fsync_ff;
    logic [8:0] bcnt_ff;
    logic cmd_ready_ff;
    logic rsp_valid_ff;
    logic [CHAN_W-1:0] rsp_chan_ff;
    logic [7:0] rsp_byte_ff;
    logic rsp_end_ff;
    logic rsp_ok_ff;
    logic [CHAN_W-1:0] chd_ff;
    logic [NUM_ENG-1:0] etx_ff;
    logic [NUM_ENG-1:0] pcmo_ff;

    logic [7:0] txsr_ff [NUM_ENG];
    logic [7:0] txhold_ff [NUM_ENG];
    logic [7:0] ersr_ff [NUM_ENG];
    logic [7:0] erhold_ff [NUM_ENG];
    logic [CHAN_W-1:0] route_ff [NUM_ENG];
    logic [SLOT_W-1:0] slot_ff [NUM_ENG];
    logic [CHAN_W-1:0] rxsrc_ff [NUM_ENG];

    wire [NUM_ENG-1:0] pipe_ready;
    wire [NUM_ENG-1:0] pipe_rxv;
    wire [NUM_ENG-1:0] pipe_rxe;
    wire [NUM_ENG-1:0] pipe_rxok;
    wire [7:0] pipe_rxb [NUM_ENG];

    wire [16:0] nco_sum = 17'(nco_ff + NCO_STEP);
    wire nco_hit = (nco_sum >= CLK_RATE_KHZ);
    wire [16:0] nco_nx = nco_hit ? 17'(nco_sum - CLK_RATE_KHZ) : nco_sum;

    wire [2:0] rd_idx = 3'(3'h7 - bcnt_ff[2:0]);
    wire frame_start = stb_ff && (bcnt_ff == FRAME_FIRST_BIT);
    wire [NUM_ENG-1:0] eng_rx = mezz_rx;

    wire grp_ok = &(pipe_ready | ~cmd_group);
    wire take_cmd = cmd_valid && cmd_ready_ff && grp_ok;

    assign cmd_ready = cmd_ready_ff;
    assign rsp_valid = rsp_valid_ff;
    assign rsp_chan = rsp_chan_ff;
    assign rsp_byte = rsp_byte_ff;
    assign rsp_end = rsp_end_ff;
    assign rsp_ok = rsp_ok_ff;
    assign pcm_out = pcmo_ff;
    assign bit_stb = stb_ff;
    assign frame_sync = fsync_ff;
    assign mezz_tx = etx_ff;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            nco_ff <= 17'h0_0000;
            stb_ff <= 1'b0;
            fsync_ff <= 1'b0;
        end else begin
            nco_ff <= nco_nx;
            stb_ff <= nco_hit;
            fsync_ff <= nco_hit && (bcnt_ff == FRAME_FIRST_BIT);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bcnt_ff <= FRAME_FIRST_BIT;
        end else if (stb_ff) begin
            bcnt_ff <= 9'(bcnt_ff + 9'h001);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cmd_ready_ff <= 1'b0;
        end else begin
            cmd_ready_ff <= !take_cmd && grp_ok;
        end
    end

    // Channel pipes emit at most one event per bit time, so one slot
    // index taken at the bit strobe selects the only possible source.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            chd_ff <= 5'h00;
            rsp_valid_ff <= 1'b0;
            rsp_chan_ff <= 5'h00;
            rsp_byte_ff <= 8'h00;
            rsp_end_ff <= 1'b0;
            rsp_ok_ff <= 1'b0;
        end else begin
            if (stb_ff) begin
                chd_ff <= bcnt_ff[7:3];
            end
            rsp_valid_ff <= pipe_rxv[chd_ff];
            rsp_end_ff <= pipe_rxe[chd_ff];
            if (pipe_rxv[chd_ff] || pipe_rxe[chd_ff]) begin
                rsp_chan_ff <= chd_ff;
                rsp_byte_ff <= pipe_rxb[chd_ff];
                rsp_ok_ff <= pipe_rxok[chd_ff];
            end
        end
    end

    pipe_if pb [NUM_ENG] ();

    for (genvar g = 0; g < NUM_ENG; g++) begin : g_lane
        wire ch_en = stb_ff && slot_match(6'(g), bcnt_ff);
        wire eng_hit = slot_match(slot_ff[g], bcnt_ff);
        // At the frame start edge the hold is still being refreshed, so the finished byte is read directly.
        wire [7:0] eng_src = frame_start ? txsr_ff[route_ff[g]] : txhold_ff[route_ff[g]];
        wire [7:0] ch_src = frame_start ? ersr_ff[rxsrc_ff[g]] : erhold_ff[rxsrc_ff[g]];
        wire eng_sel = map_wr && (map_engine == 5'(g));
        wire chan_sel = map_wr && (map_chan == 5'(g));

        assign pb[g].bit_en = ch_en;
        assign pb[g].rx_bit = ch_src[rd_idx];
        assign pb[g].tx_load = take_cmd && cmd_group[g];
        assign pb[g].tx_byte = cmd_byte;
        assign pb[g].tx_last = cmd_last;
        assign pipe_ready[g] = pb[g].tx_ready;
        assign pipe_rxv[g] = pb[g].rx_valid;
        assign pipe_rxe[g] = pb[g].rx_end;
        assign pipe_rxok[g] = pb[g].rx_ok;
        assign pipe_rxb[g] = pb[g].rx_byte;

        hdlc_pipe u_pipe (
            .ref_clk(ref_clk),
            .srst(srst),
            .bus(pb[g])
        );

        always_ff @(posedge ref_clk) begin
            if (srst) begin
                route_ff[g] <= 5'(g);
                slot_ff[g] <= CMD_SLOT_RST;
                rxsrc_ff[g] <= 5'(g);
            end else begin
                if (eng_sel) begin
                    route_ff[g] <= map_chan;
                    slot_ff[g] <= map_slot;
                end
                if (chan_sel) begin
                    rxsrc_ff[g] <= map_engine;
                end
            end
        end

        always_ff @(posedge ref_clk) begin
            if (srst) begin
                txsr_ff[g] <= IDLE_BYTE;
                txhold_ff[g] <= IDLE_BYTE;
            end else begin
                if (ch_en) begin
                    txsr_ff[g] <= {txsr_ff[g][6:0], pb[g].tx_bit};
                end
                if (frame_start) begin
                    txhold_ff[g] <= txsr_ff[g];
                end
            end
        end

        always_ff @(posedge ref_clk) begin
            if (srst) begin
                etx_ff[g] <= 1'b1;
                pcmo_ff[g] <= 1'b1;
            end else if (stb_ff) begin
                etx_ff[g] <= eng_hit ? eng_src[rd_idx] : pcm_in[g];
                pcmo_ff[g] <= eng_hit ? 1'b1 : eng_rx[g];
            end
        end

        always_ff @(posedge ref_clk) begin
            if (srst) begin
                ersr_ff[g] <= IDLE_BYTE;
                erhold_ff[g] <= IDLE_BYTE;
            end else begin
                if (stb_ff && eng_hit) begin
                    ersr_ff[g] <= {ersr_ff[g][6:0], eng_rx[g]};
                end
                if (frame_start) begin
                    erhold_ff[g] <= ersr_ff[g];
                end
            end
        end
    end
endmodule

//--- hdlc_dist_monitor.sv
module slot_dist_checker (
    // Clock and reset.
    input logic ref_clk,
    input logic srst,
    // Command and response sides.
    input logic cmd_valid,
    input logic cmd_ready,
    input logic rsp_valid,
    input logic rsp_end,
    input logic rsp_ok,
    // Engine streams and timing.
    input logic [hdlc_dist_pkg::NUM_ENG-1:0] pcm_out,
    input logic [hdlc_dist_pkg::NUM_MEZZ-1:0][hdlc_dist_pkg::ENG_PER_MEZZ-1:0] mezz_tx,
    input logic bit_stb,
    input logic frame_sync
);
    logic [4:0] gap_ff;
    logic [8:0] bits_ff;
    logic stb_seen_ff, sync_seen_ff;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            gap_ff <= 5'h00;
            bits_ff <= 9'h000;
            stb_seen_ff <= 1'b0;
            sync_seen_ff <= 1'b0;
        end else begin
            gap_ff <= bit_stb ? 5'h00 : gap_ff + 5'h01;
            bits_ff <= frame_sync ? 9'h000 : bits_ff + 9'(bit_stb);
            stb_seen_ff <= stb_seen_ff | bit_stb;
            sync_seen_ff <= sync_seen_ff | frame_sync;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    a_take_drops_ready: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
        else $error("ready stayed high after a take");
    a_stb_spacing: assert property (bit_stb && stb_seen_ff |-> gap_ff inside {5'h1D, 5'h1E})
        else $error("bit strobe spacing off");
    a_stb_pulse: assert property (bit_stb |=> !bit_stb [*8])
        else $error("bit strobe too close");
    a_first_bit_sync: assert property (bit_stb && !stb_seen_ff |-> frame_sync)
        else $error("first strobe lacks frame sync");
    a_frame_length: assert property (bit_stb && sync_seen_ff |-> frame_sync == (bits_ff == 9'h1FF))
        else $error("frame is not 512 bits");
    a_sync_on_stb: assert property (frame_sync |-> bit_stb)
        else $error("frame sync without strobe");
    a_lines_hold: assert property (!$past(bit_stb) |-> $stable(mezz_tx) && $stable(pcm_out))
        else $error("lines moved between bits");
    a_event_after_stb: assert property (rsp_valid || rsp_end |-> $past(bit_stb, 2))
        else $error("response event off strobe");
    a_ok_with_end: assert property (rsp_ok |-> rsp_end)
        else $error("frame status without frame end");
    a_reset_idle: assert property ($fell(srst) |-> &mezz_tx && &pcm_out && !cmd_ready && !bit_stb)
        else $error("outputs not idle after reset");

    c_take: cover property (cmd_valid && cmd_ready);
    c_good_frame: cover property (rsp_end && rsp_ok);
    c_frame: cover property (frame_sync);
endmodule

bind hdlc_command_slot_distributor slot_dist_checker i_chk (
    .ref_clk(ref_clk),
    .srst(srst),
    .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid),
    .rsp_end(rsp_end),
    .rsp_ok(rsp_ok),
    .pcm_out(pcm_out),
    .mezz_tx(mezz_tx),
    .bit_stb(bit_stb),
    .frame_sync(frame_sync)
);

//--- dsp_engine_model.sv
module dsp_engine_model (
    // Clock and reset.
    input logic ref_clk,
    input logic srst,
    // Engine lines and stream timing.
    input logic bit_stb,
    input logic frame_sync,
    input logic [31:0] mezz_tx,
    input logic [31:0] pcm_in,
    input logic [31:0] pcm_out,
    output logic [31:0] mezz_rx,
    // Scenario control.
    input logic [5:0] eng_slot [32],
    input logic rsp_go,
    input logic [4:0] rsp_eng,
    input logic [7:0] rsp_data,
    // Observations.
    output logic [7:0] got_byte [32],
    output int got_cnt [32],
    output int line_bad,
    output int line_checks
);
    import hdlc_dist_pkg::*;
    logic [8:0] pend_pos, prev_pos, cur;
    logic have_last, act;
    logic bitq [$];
    logic [7:0] sh [32];
    logic [23:0] hist [32];
    logic [15:0] crc [32];
    int ones [32], nb [32], nbytes [32];

    function automatic logic [15:0] fold(input logic [15:0] c, input logic [7:0] x);
        for (int i = 0; i < 8; i++) begin
            c = (c >> 1) ^ ((c[0] ^ x[i]) ? CRC_POLY : 16'h0000);
        end
        return c;
    endfunction

    task automatic put(input logic b, inout int run);
        bitq.push_back(b);
        run = b ? run + 1 : 0;
        if (run == 5) begin
            bitq.push_back(1'b0);
            run = 0;
        end
    endtask

    task automatic take(input int e, input logic b);
        if (ones[e] == 5 && !b) begin
            ones[e] = 0;
            return;
        end
        ones[e] = b ? ones[e] + 1 : 0;
        sh[e] = {b, sh[e][7:1]};
        nb[e]++;
        if (ones[e] > 6) begin
            nb[e] = 0;
            nbytes[e] = 0;
        end else if (sh[e] == HDLC_FLAG) begin
            if (nbytes[e] >= 3 && crc[e] == CRC_RESIDUE) begin
                got_byte[e] = hist[e][7:0];
                got_cnt[e]++;
            end
            nb[e] = 0;
            nbytes[e] = 0;
            crc[e] = CRC_INIT;
        end else if (nb[e] == 8) begin
            crc[e] = fold(crc[e], sh[e]);
            hist[e] = {sh[e], hist[e][23:8]};
            nbytes[e]++;
            nb[e] = 0;
        end
    endtask

    always @(posedge rsp_go) begin : build
        logic [23:0] body;
        int run;
        body = {~fold(CRC_INIT, rsp_data), rsp_data};
        run = 0;
        for (int i = 0; i < 8; i++)
            bitq.push_back(HDLC_FLAG[i]);
        for (int i = 0; i < 24; i++)
            put(body[i], run);
        for (int i = 0; i < 8; i++)
            bitq.push_back(HDLC_FLAG[i]);
        // Padding keeps the frame aligned to whole slots.
        while (bitq.size() % 8 != 0)
            bitq.push_back(1'b1);
    end

    initial mezz_rx = 32'hFFFF_FFFF;

    always @(posedge ref_clk) begin
        if (srst) begin
            pend_pos = 9'h000;
            have_last = 1'b0;
            act = 1'b0;
            line_bad = 0;
            line_checks = 0;
            for (int e = 0; e < 32; e++) begin
                ones[e] = 0;
                nb[e] = 0;
                nbytes[e] = 0;
                crc[e] = CRC_INIT;
                got_cnt[e] = 0;
            end
        end else if (bit_stb) begin
            cur = frame_sync ? 9'h000 : pend_pos;
            for (int e = 0; e < 32; e++) begin
                if (have_last && prev_pos[8:3] != eng_slot[e]) begin
                    line_checks++;
                    if (mezz_tx[e] !== pcm_in[e] || pcm_out[e] !== (e[0] ^ prev_pos[0] ^ prev_pos[3]))
                        line_bad++;
                end else if (have_last) begin
                    if (pcm_out[e] !== 1'b1)
                        line_bad++;
                    take(e, mezz_tx[e]);
                end
            end
            if (act && cur[8:3] == eng_slot[rsp_eng])
                void'(bitq.pop_front());
            if (cur[8:3] == eng_slot[rsp_eng] && cur[2:0] == 3'h7)
                act = bitq.size() > 0;
            have_last = 1'b1;
            prev_pos = cur;
            pend_pos = cur + 9'h001;
        end
        for (int e = 0; e < 32; e++) begin
            if (pend_pos[8:3] != eng_slot[e])
                mezz_rx[e] <= e[0] ^ pend_pos[0] ^ pend_pos[3];
            else if (act && e == rsp_eng)
                mezz_rx[e] <= bitq[0];
            else
                mezz_rx[e] <= HDLC_FLAG[pend_pos[2:0]];
        end
    end
endmodule

//--- tb_hdlc_command_slot_distributor.sv
module tb_hdlc_command_slot_distributor;
    timeunit 1ns;
    timeprecision 1ps;
    import hdlc_dist_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic cmd_valid, cmd_last, cmd_ready, map_wr, rsp_valid, rsp_end, rsp_ok, bit_stb, frame_sync, rsp_go;
    logic [31:0] cmd_group, pcm_in, pcm_out;
    logic [7:0] cmd_byte, rsp_byte, rsp_data;
    logic [4:0] rsp_chan, map_engine, map_chan, rsp_eng;
    logic [5:0] map_slot;
    logic [3:0][7:0] mezz_tx, mezz_rx;
    logic [5:0] eng_slot [32];
    logic [7:0] got_byte [32];
    int got_cnt [32], line_bad, line_checks;
    int mismatches = 0;
    int total_checks = 0;

    always #4 ref_clk = ~ref_clk;

    hdlc_command_slot_distributor i_dut (.ref_clk(ref_clk), .srst(srst), .cmd_valid(cmd_valid),
        .cmd_group(cmd_group), .cmd_byte(cmd_byte), .cmd_last(cmd_last), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_chan(rsp_chan), .rsp_byte(rsp_byte), .rsp_end(rsp_end), .rsp_ok(rsp_ok),
        .map_wr(map_wr), .map_engine(map_engine), .map_chan(map_chan), .map_slot(map_slot),
        .pcm_in(pcm_in), .pcm_out(pcm_out), .mezz_tx(mezz_tx), .mezz_rx(mezz_rx),
        .bit_stb(bit_stb), .frame_sync(frame_sync));

    dsp_engine_model i_eng (.ref_clk(ref_clk), .srst(srst), .bit_stb(bit_stb), .frame_sync(frame_sync),
        .mezz_tx(mezz_tx), .pcm_in(pcm_in), .pcm_out(pcm_out), .mezz_rx(mezz_rx), .eng_slot(eng_slot),
        .rsp_go(rsp_go), .rsp_eng(rsp_eng), .rsp_data(rsp_data), .got_byte(got_byte), .got_cnt(got_cnt),
        .line_bad(line_bad), .line_checks(line_checks));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic offer(input logic [31:0] group, input logic [7:0] data);
        cmd_valid = 1'b1;
        cmd_group = group;
        cmd_byte = data;
        for (int i = 0; i < 40000 && cmd_ready !== 1'b1; i++)
            step(1);
        step(1);
        cmd_valid = 1'b0;
        check(cmd_ready, 1'h0);
    endtask

    task automatic t_reset;
        check(mezz_tx, 32'hFFFF_FFFF);
        check(pcm_out, 32'hFFFF_FFFF);
        check({cmd_ready, bit_stb}, 2'h0);
        map_wr = 1'b1;
        map_engine = 5'h09;
        map_chan = 5'h09;
        map_slot = 6'h05;
        eng_slot[9] = 6'h05;
        step(1);
        map_wr = 1'b0;
        check(cmd_ready, 1'h1);
        offer(32'h0000_0000, 8'h55);
        $display("reset test done");
    endtask

    task automatic t_duplex;
        logic got_v = 1'b0, got_e = 1'b0;
        int cyc = 0, stb = 0, ns = 0;
        rsp_go = 1'b1;
        offer(32'h0000_0201, 8'h3C);
        rsp_go = 1'b0;
        for (int i = 0; i < 130000 && !(got_e && got_cnt[0] > 0 && got_cnt[9] > 0); i++) begin
            step(1);
            if (ns == 1) begin
                cyc++;
                stb += int'(bit_stb === 1'b1);
            end
            ns += int'(frame_sync === 1'b1);
            if (rsp_valid === 1'b1) begin
                got_v = 1'b1;
                check({rsp_chan, rsp_byte}, 13'h03A5);
            end
            if (rsp_end === 1'b1) begin
                got_e = 1'b1;
                check({rsp_chan, rsp_ok}, 6'h07);
            end
        end
        check(cyc, 32'h0000_3D09);
        check(stb, 32'h0000_0200);
        check({got_v, got_e}, 2'h3);
        check(got_byte[0], 8'h3C);
        check(got_byte[9], 8'h3C);
        check(got_cnt[1], 32'h0000_0000);
        check(line_bad, 32'h0000_0000);
        check(line_checks > 0, 1'h1);
        $display("duplex test done");
    endtask

    initial begin
        cmd_valid = 1'b0;
        cmd_group = 32'h0000_0000;
        cmd_byte = 8'h00;
        cmd_last = 1'b1;
        map_wr = 1'b0;
        map_engine = 5'h00;
        map_chan = 5'h00;
        map_slot = 6'h00;
        pcm_in = 32'h96C3_5AF0;
        rsp_go = 1'b0;
        rsp_eng = 5'h03;
        rsp_data = 8'hA5;
        eng_slot = '{default: 6'h00};
        step(2);
        srst = 1'b0;
        t_reset();
        t_duplex();
        report_and_stop();
    end

    initial begin
        repeat (140000) @(posedge ref_clk);
        mismatches++;
        report_and_stop();
    end
endmodule
